// file: shared/coc_defines.svh
`ifndef COC_DEFINES_SVH
`define COC_DEFINES_SVH
// Register byte offsets.
`define COC_REG_DATA    8'h00
`define COC_REG_FEAT    8'h04
`define COC_REG_CMD     8'h08
`define COC_REG_STATUS  8'h0C
`define COC_REG_ERROR   8'h10
`define COC_REG_SECCNT  8'h14
`define COC_REG_SECNUM  8'h18
`define COC_REG_CYLLO   8'h1C
`define COC_REG_CYLHI   8'h20
`define COC_REG_CTRL    8'h24
`define COC_REG_CUR0    8'h28
`define COC_REG_CUR1    8'h2C
`define COC_REG_CUR2    8'h30
// Control register bit positions.
`define COC_CTL_SRST    0
`define COC_CTL_SEC_EN  1
`define COC_CTL_SEC_LK  2
`define COC_CTL_HPA     3
`define COC_CTL_MAX_LK  4
`define COC_CTL_NOSUP   5
// Command and subcommand codes.
`define COC_CMD_OVL     8'hB1
`define COC_SUB_RESTORE 8'hC0
`define COC_SUB_FREEZE  8'hC1
`define COC_SUB_IDENT   8'hC2
`define COC_SUB_SET     8'hC3
// Abort reason codes.
`define COC_RSN_FROZEN  8'h01
`define COC_RSN_SECLK   8'h02
`define COC_RSN_MODIF   8'h03
`define COC_RSN_DISABLE 8'h04
`define COC_RSN_MAXLK   8'h05
`define COC_RSN_HPA     8'h06
`define COC_RSN_NOSUP   8'h07
`define COC_RSN_BADSUB  8'h08
`define COC_RSN_OTHER   8'hFF
// Overlay block layout.
`define COC_REV         16'h0002
`define COC_SIG         8'hA5
`define COC_W_REV       8'h00
`define COC_W_MWDMA     8'h01
`define COC_W_UDMA      8'h02
`define COC_W_LBA0      8'h03
`define COC_W_LBA3      8'h06
`define COC_W_CMDSET    8'h07
`define COC_W_SATA      8'h08
`define COC_W_WUNC      8'h15
`define COC_W_LAST      8'hFF
`define COC_SEC_BIT     3
`define COC_SEC_MASK    16'h0008
// Full selectable capability set.
`define COC_FULL_W1     16'h0007
`define COC_FULL_W2     16'h007F
`define COC_FULL_W7     16'h1BBF
`define COC_FULL_W8     16'h0007
`define COC_FULL_W21    16'h2000
`define COC_ZERO8       8'h00
`define COC_ZERO16      16'h0000
`define COC_ZERO32      32'h0000_0000
`define COC_RESP_OK     2'b00
`define COC_RESP_ERR    2'b10
`endif

// file: shared/coc_pkg.sv
package coc_pkg;
	typedef enum logic [1:0] {
		COC_IDLE = 2'b00,
		COC_DIN  = 2'b01,
		COC_DOUT = 2'b10
	} coc_state_t;

	typedef struct packed {
		coc_state_t  state;
		logic [7:0]  feat;
		logic        drq;
		logic        err;
		logic [7:0]  seccnt;
		logic [7:0]  secnum;
		logic [7:0]  cyllo;
		logic [7:0]  cylhi;
		logic [7:0]  idx;
		logic        frozen;
		logic        modified;
		logic [5:0]  ctrl;
		logic [15:0] cur_w1;
		logic [15:0] cur_w2;
		logic [15:0] cur_w7;
		logic [15:0] cur_w8;
		logic [15:0] cur_w21;
		logic [15:0] new_w1;
		logic [15:0] new_w2;
		logic [15:0] new_w7;
		logic [15:0] new_w8;
		logic [15:0] new_w21;
		logic        lba_req;
		logic        awready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} coc_regs_t;
endpackage

// file: logic/coc_unit.sv
`timescale 1ns/1ps
`include "coc_defines.svh"
// Summary of operation
// RQ1 - Features value selects restore, freeze, identify, set.
// RQ2 - Restore cancels reductions back to full set.
// RQ3 - After freeze, all overlay subcommands abort.
// RQ4 - Freeze survives resets, cleared only at power-up.
// RQ5 - Identify returns one 512-byte block by PIO.
// RQ6 - Normal identify reduced; overlay identify stays full.
// RQ7 - Set clears capability bits in identify words.
// RQ8 - Set bits absent from full set are ignored.
// RQ9 - Abort reports reason and word index.
// RQ10 - Abort reports bit mask across two registers.
// RQ11 - Reasons 01h frozen, 02h locked, 03h modified.
// RQ12 - Reasons 04h disable, 05h max locked, 06h area.
// RQ13 - Reasons 07h unsupported, 08h bad subcommand, FFh other.
// RQ14 - Protected area blocks maximum address change.
// RQ15 - Disabling enabled security aborts with word 7 bit 3.
// RQ16 - Word 0 revision, word 1 multiword DMA modes.
// RQ17 - Word 2 holds Ultra DMA modes.
// RQ18 - Word 7 holds command and feature set flags.
// RQ19 - Word 8 holds serial link feature flags.
// RQ20 - Word 21 holds write uncorrectable flag.
// RQ21 - Word 255 holds signature and checksum.
// RQ22 - Checksum makes all block bytes sum zero.
// RQ23 - Reserved bits and words read as zero.
// RQ24 - Host checks signature and checksum before use.
module coc_unit
	import coc_pkg::*;
(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address and data.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// Write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// Read address and data.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	coc_regs_t r_reg;
	coc_regs_t r_next;
	logic [7:0]  chk;
	logic [15:0] blk_word;
	logic [7:0]  status;
	logic        wr;
	logic        rd;
	logic        issue;
	logic        bad_sub;

	// Word constants as named values so that their bytes can be selected.
	localparam logic [15:0] rev_w    = `COC_REV;
	localparam logic [15:0] full_w1  = `COC_FULL_W1;
	localparam logic [15:0] full_w2  = `COC_FULL_W2;
	localparam logic [15:0] full_w7  = `COC_FULL_W7;
	localparam logic [15:0] full_w8  = `COC_FULL_W8;
	localparam logic [15:0] full_w21 = `COC_FULL_W21;
	localparam logic [15:0] sec_mask = `COC_SEC_MASK;

	////////////////////////////////////////////////////////////////////////////
	// Overlay block content.
	always_comb
	begin
		chk = `COC_ZERO8 - (rev_w[15:8] + rev_w[7:0] + full_w1[15:8] + full_w1[7:0] //RQ22
			+ full_w2[15:8] + full_w2[7:0] + full_w7[15:8] + full_w7[7:0]
			+ full_w8[15:8] + full_w8[7:0] + full_w21[15:8] + full_w21[7:0] + `COC_SIG);
		unique case (r_reg.idx)
			`COC_W_REV:    blk_word = `COC_REV; //RQ16
			`COC_W_MWDMA:  blk_word = `COC_FULL_W1; //RQ16
			`COC_W_UDMA:   blk_word = `COC_FULL_W2; //RQ17
			`COC_W_CMDSET: blk_word = `COC_FULL_W7; //RQ18
			`COC_W_SATA:   blk_word = `COC_FULL_W8; //RQ19
			`COC_W_WUNC:   blk_word = `COC_FULL_W21; //RQ20
			`COC_W_LAST:   blk_word = {chk, `COC_SIG}; //RQ21
			default:       blk_word = `COC_ZERO16; //RQ23
		endcase
	end

	assign status  = {1'b0, 1'b1, 1'b0, 1'b1, r_reg.drq, 2'b00, r_reg.err};
	assign wr      = s_axi_awvalid && r_reg.awready;
	assign rd      = s_axi_arvalid && r_reg.arready;
	assign issue   = wr && s_axi_wstrb[0] && s_axi_awaddr == `COC_REG_CMD;
	assign bad_sub = r_reg.feat < `COC_SUB_RESTORE || r_reg.feat > `COC_SUB_SET; //RQ1

	////////////////////////////////////////////////////////////////////////////
	// Bus handshakes, command interpretation and data transfer.
	always_comb
	begin
		r_next = r_reg;
		// Write channel takes address and data in the same cycle.
		r_next.awready = 1'b0;
		if (s_axi_awvalid && s_axi_wvalid && !r_reg.awready && !r_reg.bvalid)
			r_next.awready = 1'b1;
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;
		r_next.arready = 1'b0;
		if (s_axi_arvalid && !r_reg.arready && !r_reg.rvalid)
			r_next.arready = 1'b1;
		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'b0;
		if (r_reg.ctrl[`COC_CTL_SRST])
		begin
			// Soft reset clears the command state but keeps the freeze lock.
			r_next.state  = COC_IDLE; //RQ4
			r_next.drq    = 1'b0;
			r_next.err    = 1'b0;
			r_next.idx    = `COC_ZERO8;
			r_next.ctrl[`COC_CTL_SRST] = 1'b0;
		end
		if (wr)
		begin
			r_next.bvalid = 1'b1;
			r_next.bresp  = `COC_RESP_OK;
			if (s_axi_wstrb[0])
			begin
				unique case (s_axi_awaddr)
					`COC_REG_FEAT: r_next.feat = s_axi_wdata[7:0];
					`COC_REG_CTRL: r_next.ctrl = s_axi_wdata[5:0];
					`COC_REG_CMD:  ;
					`COC_REG_DATA:
					begin
						if (r_reg.state == COC_DOUT)
						begin
							// Set data: keep only bits the full set allows.
							unique case (r_reg.idx)
								`COC_W_MWDMA:  r_next.new_w1 = s_axi_wdata[15:0] & `COC_FULL_W1; //RQ8
								`COC_W_UDMA:   r_next.new_w2 = s_axi_wdata[15:0] & `COC_FULL_W2; //RQ8
								`COC_W_CMDSET: r_next.new_w7 = s_axi_wdata[15:0] & `COC_FULL_W7; //RQ8
								`COC_W_SATA:   r_next.new_w8 = s_axi_wdata[15:0] & `COC_FULL_W8; //RQ8
								`COC_W_WUNC:   r_next.new_w21 = s_axi_wdata[15:0] & `COC_FULL_W21; //RQ8
								default:
								begin
									if (r_reg.idx >= `COC_W_LBA0 && r_reg.idx <= `COC_W_LBA3
										&& s_axi_wdata[15:0] != `COC_ZERO16)
										r_next.lba_req = 1'b1;
								end
							endcase
							r_next.idx = r_reg.idx + 8'h01;
							if (r_reg.idx == `COC_W_LAST)
							begin
								r_next.state = COC_IDLE;
								r_next.drq   = 1'b0;
								if (r_reg.ctrl[`COC_CTL_SEC_EN] && r_reg.cur_w7[`COC_SEC_BIT]
									&& !r_reg.new_w7[`COC_SEC_BIT])
								begin
									r_next.err    = 1'b1; //RQ15
									r_next.seccnt = `COC_RSN_DISABLE; //RQ12
									r_next.cylhi  = `COC_W_CMDSET; //RQ9
									r_next.cyllo  = sec_mask[15:8]; //RQ10
									r_next.secnum = sec_mask[7:0]; //RQ10
								end
								else if (r_reg.ctrl[`COC_CTL_HPA] && r_reg.lba_req)
								begin
									r_next.err    = 1'b1; //RQ14
									r_next.seccnt = `COC_RSN_HPA; //RQ12
									r_next.cylhi  = `COC_W_LBA0; //RQ14
								end
								else
								begin
									// Reduced set becomes the normal identify content.
									r_next.cur_w1   = r_reg.new_w1; //RQ7
									r_next.cur_w2   = r_reg.new_w2; //RQ7
									r_next.cur_w7   = r_reg.new_w7; //RQ7
									r_next.cur_w8   = r_reg.new_w8; //RQ7
									r_next.cur_w21  = r_reg.new_w21; //RQ7
									r_next.modified = 1'b1;
								end
							end
						end
					end
					default: r_next.bresp = `COC_RESP_ERR;
				endcase
			end
		end
		if (issue)
		begin
			// Every new command starts as an abort with cleared reason, index and mask registers.
			r_next.state  = COC_IDLE;
			r_next.drq    = 1'b0;
			r_next.err    = 1'b1;
			r_next.seccnt = `COC_ZERO8;
			r_next.secnum = `COC_ZERO8;
			r_next.cyllo  = `COC_ZERO8;
			r_next.cylhi  = `COC_ZERO8;
			r_next.idx    = `COC_ZERO8;
			if (r_reg.ctrl[`COC_CTL_NOSUP])
				r_next.seccnt = `COC_RSN_NOSUP; //RQ13
			else if (s_axi_wdata[7:0] != `COC_CMD_OVL)
				r_next.seccnt = `COC_RSN_OTHER; //RQ13
			else if (bad_sub)
				r_next.seccnt = `COC_RSN_BADSUB; //RQ13
			else if (r_reg.frozen)
				r_next.seccnt = `COC_RSN_FROZEN; //RQ3
			else if (r_reg.ctrl[`COC_CTL_SEC_LK])
				r_next.seccnt = `COC_RSN_SECLK; //RQ11
			else
			begin
				r_next.err = 1'b0;
				unique case (r_reg.feat)
					`COC_SUB_RESTORE:
					begin
						if (r_reg.ctrl[`COC_CTL_HPA])
						begin
							r_next.err    = 1'b1; //RQ14
							r_next.seccnt = `COC_RSN_HPA;
							r_next.cylhi  = `COC_W_LBA0;
						end
						else
						begin
							r_next.cur_w1   = `COC_FULL_W1; //RQ2
							r_next.cur_w2   = `COC_FULL_W2; //RQ2
							r_next.cur_w7   = `COC_FULL_W7; //RQ2
							r_next.cur_w8   = `COC_FULL_W8; //RQ2
							r_next.cur_w21  = `COC_FULL_W21; //RQ2
							r_next.modified = 1'b0;
						end
					end
					`COC_SUB_FREEZE: r_next.frozen = 1'b1; //RQ3
					`COC_SUB_IDENT:
					begin
						r_next.state = COC_DIN; //RQ5
						r_next.drq   = 1'b1;
					end
					default:
					begin
						if (r_reg.modified)
						begin
							r_next.err    = 1'b1;
							r_next.seccnt = `COC_RSN_MODIF; //RQ11
						end
						else if (r_reg.ctrl[`COC_CTL_MAX_LK])
						begin
							r_next.err    = 1'b1;
							r_next.seccnt = `COC_RSN_MAXLK; //RQ12
						end
						else
						begin
							r_next.state   = COC_DOUT;
							r_next.drq     = 1'b1;
							r_next.lba_req = 1'b0;
							r_next.new_w1  = `COC_ZERO16;
							r_next.new_w2  = `COC_ZERO16;
							r_next.new_w7  = `COC_ZERO16;
							r_next.new_w8  = `COC_ZERO16;
							r_next.new_w21 = `COC_ZERO16;
						end
					end
				endcase
			end
		end
		if (rd)
		begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = `COC_RESP_OK;
			r_next.rdata  = `COC_ZERO32;
			unique case (s_axi_araddr)
				`COC_REG_DATA:
				begin
					if (r_reg.state == COC_DIN)
					begin
						// Each read pops one block word; the last ends the transfer.
						r_next.rdata[15:0] = blk_word; //RQ5
						r_next.idx = r_reg.idx + 8'h01;
						if (r_reg.idx == `COC_W_LAST)
						begin
							r_next.state = COC_IDLE; //RQ5
							r_next.drq   = 1'b0;
						end
					end
				end
				`COC_REG_FEAT:   r_next.rdata[7:0] = r_reg.feat;
				`COC_REG_CMD:    r_next.rdata[7:0] = status;
				`COC_REG_STATUS: r_next.rdata[7:0] = status;
				`COC_REG_ERROR:  r_next.rdata[7:0] = {5'b00000, r_reg.err, 2'b00};
				`COC_REG_SECCNT: r_next.rdata[7:0] = r_reg.seccnt; //RQ9
				`COC_REG_SECNUM: r_next.rdata[7:0] = r_reg.secnum; //RQ10
				`COC_REG_CYLLO:  r_next.rdata[7:0] = r_reg.cyllo; //RQ10
				`COC_REG_CYLHI:  r_next.rdata[7:0] = r_reg.cylhi; //RQ9
				`COC_REG_CTRL:   r_next.rdata[5:0] = r_reg.ctrl;
				`COC_REG_CUR0:   r_next.rdata = {r_reg.cur_w2, r_reg.cur_w1}; //RQ6
				`COC_REG_CUR1:   r_next.rdata = {r_reg.cur_w8, r_reg.cur_w7}; //RQ6
				`COC_REG_CUR2:   r_next.rdata[15:0] = r_reg.cur_w21; //RQ6
				default:         r_next.rresp = `COC_RESP_ERR;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; aresetn is the power-up reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r_reg          <= '0;
			r_reg.state    <= COC_IDLE;
			r_reg.cur_w1   <= `COC_FULL_W1;
			r_reg.cur_w2   <= `COC_FULL_W2;
			r_reg.cur_w7   <= `COC_FULL_W7;
			r_reg.cur_w8   <= `COC_FULL_W8;
			r_reg.cur_w21  <= `COC_FULL_W21;
			r_reg.frozen   <= 1'b0; //RQ4
		end
		else
			r_reg <= r_next;
	end

	assign s_axi_awready = r_reg.awready;
	assign s_axi_wready  = r_reg.awready;
	assign s_axi_bvalid  = r_reg.bvalid;
	assign s_axi_bresp   = r_reg.bresp;
	assign s_axi_arready = r_reg.arready;
	assign s_axi_rvalid  = r_reg.rvalid;
	assign s_axi_rresp   = r_reg.rresp;
	assign s_axi_rdata   = r_reg.rdata;

	////////////////////////////////////////////////////////////////////////////
	// Assertions and covers.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic go;
	assign go = issue && !r_reg.ctrl[`COC_CTL_NOSUP] && s_axi_wdata[7:0] == `COC_CMD_OVL
		&& !bad_sub;

	freeze_abort_a: assert property (go && r_reg.frozen //RQ3
		|=> r_reg.err && r_reg.seccnt == `COC_RSN_FROZEN)
		else $error("Frozen overlay command not aborted.");
	freeze_hold_a: assert property (r_reg.frozen |=> r_reg.frozen) //RQ4
		else $error("Freeze lock lost without power-up.");
	bad_sub_a: assert property (issue && !r_reg.ctrl[`COC_CTL_NOSUP] //RQ13
		&& s_axi_wdata[7:0] == `COC_CMD_OVL && bad_sub |=> r_reg.seccnt == `COC_RSN_BADSUB)
		else $error("Invalid subcommand not reported.");
	ident_start_a: assert property (go && !r_reg.frozen && !r_reg.ctrl[`COC_CTL_SEC_LK] //RQ5
		&& r_reg.feat == `COC_SUB_IDENT |=> r_reg.state == COC_DIN && r_reg.idx == `COC_ZERO8)
		else $error("Identify did not start a data-in transfer.");
	ident_end_a: assert property (rd && s_axi_araddr == `COC_REG_DATA //RQ5
		&& r_reg.state == COC_DIN && r_reg.idx == `COC_W_LAST |=> r_reg.state == COC_IDLE && !r_reg.drq)
		else $error("Identify block did not end after word 255.");
	cap_mask_a: assert property ((r_reg.cur_w7 & ~`COC_FULL_W7) == `COC_ZERO16 //RQ8
		&& (r_reg.cur_w2 & ~`COC_FULL_W2) == `COC_ZERO16)
		else $error("Reduced set holds a capability outside the full set.");
	checksum_a: assert property (rd && s_axi_araddr == `COC_REG_DATA //RQ21
		&& r_reg.state == COC_DIN && r_reg.idx == `COC_W_LAST
		|=> r_reg.rdata[7:0] == `COC_SIG && r_reg.rdata[15:8] == chk)
		else $error("Last block word lacks signature or checksum.");
	hpa_abort_a: assert property (go && !r_reg.frozen && !r_reg.ctrl[`COC_CTL_SEC_LK] //RQ14
		&& r_reg.feat == `COC_SUB_RESTORE && r_reg.ctrl[`COC_CTL_HPA]
		|=> r_reg.seccnt == `COC_RSN_HPA && r_reg.cylhi == `COC_W_LBA0 && r_reg.secnum == `COC_ZERO8)
		else $error("Restore with protected area not aborted correctly.");

	ident_c: cover property (r_reg.state == COC_DIN ##1 r_reg.state == COC_IDLE);
	set_c: cover property (r_reg.state == COC_DOUT ##1 r_reg.modified);
	freeze_c: cover property (go && r_reg.frozen);
endmodule // coc_unit

// file: testbench/coc_host_model.sv
`timescale 1ns/1ps
`include "coc_defines.svh"
// Host model: drives the register bus and moves PIO words.
module coc_host_model
(
	// Clock.
	input  wire logic        aclk,
	// Write side.
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	// Read side.
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	logic [15:0] blk [0:255];
	logic        blk_ok;
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, blk_ok} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr  <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata  <= ~d;
			end
			if (s_axi_bvalid)
			begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr  <= ~a;
			end
			if (s_axi_rvalid)
			begin
				d = s_axi_rdata;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
	// Issues the overlay command with its subcommand code.
	task automatic cmd(input logic [7:0] sub);
		wr(`COC_REG_FEAT, {24'h00_0000, sub});
		wr(`COC_REG_CMD, {24'h00_0000, `COC_CMD_OVL});
	endtask
	// Reads one overlay block and validates its signature and checksum.
	task automatic rd_block();
		int          sum;
		logic [31:0] d;
		sum = 0;
		for (int i = 0; i < 256; i++)
		begin
			rd(`COC_REG_DATA, d);
			blk[i] = d[15:0];
			sum += d[15:8] + d[7:0];
		end
		blk_ok = (blk[255][7:0] == `COC_SIG) && (sum[7:0] == 8'h00);
	endtask
endmodule // coc_host_model

// file: testbench/config_overlay_command_unit_bench.sv
`timescale 1ns/1ps
`include "coc_defines.svh"
module config_overlay_command_unit_bench;
	import coc_pkg::*;
	typedef struct packed {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} coc_note_t;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, tmp;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	coc_note_t   notes [$];
	coc_note_t   n;
	int          bad_count, checks, cycles;
	integer      seed;
	logic [7:0]  s8;
	logic [15:0] exp_blk [0:255];
	logic [15:0] sv [0:255];
	logic [7:0]  bad_v [0:3] = '{8'h00, 8'hBF, 8'hC4, 8'hFF};
	logic [5:0]  ctl_v [0:3] = '{6'h20, 6'h04, 6'h10, 6'h08};
	logic [7:0]  sub_v [0:3] = '{8'hC2, 8'hC2, 8'hC3, 8'hC0};
	logic [7:0]  rsn_v [0:3] = '{8'h07, 8'h02, 8'h05, 8'h06};
	coc_unit u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	coc_host_model u_host (.aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task automatic end_of_test();
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [33:0] seen, input logic [33:0] want);
		checks++;
		if (seen !== want)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	// Each answer on the bus takes the oldest note off the queue.
	always @(posedge aclk)
	begin
		cycles++;
		if ((bvalid && bready) || (rvalid && rready))
		begin
			n = notes.pop_front();
			if (rvalid)
				check({rresp, rdata & n.mask}, {n.resp, n.data & n.mask});
			else
				check({bresp, 32'h0000_0000}, {n.resp, 32'h0000_0000});
		end
		if (cycles == 30000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
		notes.push_back({r, 64'h0});
		u_host.wr(a, d);
	endtask
	task automatic rx(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m = 32'h0000_00FF, input logic [1:0] r = 2'b00);
		notes.push_back({r, d, m});
		u_host.rd(a, tmp);
	endtask
	task automatic cmd(input logic [7:0] sub);
		notes.push_back('0);
		notes.push_back('0);
		u_host.cmd(sub);
	endtask
	task automatic abort_chk(input logic [7:0] rsn, input logic [7:0] w, input logic [15:0] m);
		rx(`COC_REG_STATUS, 32'h51);
		rx(`COC_REG_ERROR, 32'h04);
		rx(`COC_REG_SECCNT, {24'h00_0000, rsn});
		rx(`COC_REG_CYLHI, {24'h00_0000, w});
		rx(`COC_REG_CYLLO, {24'h00_0000, m[15:8]});
		rx(`COC_REG_SECNUM, {24'h00_0000, m[7:0]});
	endtask
	task automatic ident();
		cmd(`COC_SUB_IDENT);
		rx(`COC_REG_STATUS, 32'h58);
		for (int i = 0; i < 256; i++)
			notes.push_back({2'b00, 16'h0000, exp_blk[i], 32'h0000_FFFF});
		u_host.rd_block();
		rx(`COC_REG_STATUS, 32'h50);
		check({33'h0, u_host.blk_ok}, 34'h1);
	endtask
	task automatic send_set();
		cmd(`COC_SUB_SET);
		for (int i = 0; i < 256; i++)
			wx(`COC_REG_DATA, {16'h0000, sv[i]});
	endtask
	task automatic full_set();
		foreach (sv[i])
			sv[i] = exp_blk[i];
		sv[255] = 16'h0000;
	endtask
	task automatic caps(input logic [15:0] w1, w2, w7, w8, w21);
		rx(`COC_REG_CUR0, {w2, w1}, 32'hFFFF_FFFF);
		rx(`COC_REG_CUR1, {w8, w7}, 32'hFFFF_FFFF);
		rx(`COC_REG_CUR2, {16'h0000, w21}, 32'hFFFF_FFFF);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		aresetn = 1'b0;
		seed = 32'h6be8;
		foreach (exp_blk[i])
			exp_blk[i] = 16'h0000;
		exp_blk[0] = `COC_REV;
		exp_blk[1] = `COC_FULL_W1;
		exp_blk[2] = `COC_FULL_W2;
		exp_blk[7] = `COC_FULL_W7;
		exp_blk[8] = `COC_FULL_W8;
		exp_blk[21] = `COC_FULL_W21;
		s8 = `COC_SIG;
		for (int i = 0; i < 255; i++)
			s8 = s8 + exp_blk[i][15:8] + exp_blk[i][7:0];
		exp_blk[255] = {8'h00 - s8, `COC_SIG};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rx(`COC_REG_STATUS, 32'h50);
		caps(`COC_FULL_W1, `COC_FULL_W2, `COC_FULL_W7, `COC_FULL_W8, `COC_FULL_W21);
		rx(8'h40, 32'h0, 32'hFFFF_FFFF, 2'b10);
		wx(8'h40, 32'h0, 2'b10);
		ident();
		foreach (bad_v[i])
		begin
			cmd(bad_v[i]);
			abort_chk(8'h08, 8'h00, 16'h0000);
		end
		wx(`COC_REG_FEAT, 32'hC2);
		wx(`COC_REG_CMD, 32'hEC);
		abort_chk(8'hFF, 8'h00, 16'h0000);
		foreach (ctl_v[i])
		begin
			wx(`COC_REG_CTRL, {26'h000_0000, ctl_v[i]});
			cmd(sub_v[i]);
			abort_chk(rsn_v[i], (i == 3) ? 8'h03 : 8'h00, 16'h0000);
		end
		wx(`COC_REG_CTRL, 32'h0);
		full_set();
		foreach (sv[i])
			if (i inside {1, 2, 7, 8, 21})
				sv[i] = $random(seed);
		send_set();
		rx(`COC_REG_STATUS, 32'h50);
		caps(sv[1] & `COC_FULL_W1, sv[2] & `COC_FULL_W2, sv[7] & `COC_FULL_W7,
			sv[8] & `COC_FULL_W8, sv[21] & `COC_FULL_W21);
		ident();
		cmd(`COC_SUB_SET);
		abort_chk(8'h03, 8'h00, 16'h0000);
		cmd(`COC_SUB_RESTORE);
		rx(`COC_REG_STATUS, 32'h50);
		caps(`COC_FULL_W1, `COC_FULL_W2, `COC_FULL_W7, `COC_FULL_W8, `COC_FULL_W21);
		wx(`COC_REG_CTRL, 32'h02);
		full_set();
		sv[7] = `COC_FULL_W7 & ~`COC_SEC_MASK;
		send_set();
		abort_chk(8'h04, 8'h07, 16'h0008);
		wx(`COC_REG_CTRL, 32'h08);
		full_set();
		sv[3] = $random(seed) | 32'h1;
		send_set();
		abort_chk(8'h06, 8'h03, 16'h0000);
		wx(`COC_REG_CTRL, 32'h0);
		cmd(`COC_SUB_FREEZE);
		rx(`COC_REG_STATUS, 32'h50);
		for (int i = 0; i < 4; i++)
		begin
			cmd(8'hC0 + i[7:0]);
			abort_chk(8'h01, 8'h00, 16'h0000);
		end
		wx(`COC_REG_CTRL, 32'h01);
		cmd(`COC_SUB_IDENT);
		abort_chk(8'h01, 8'h00, 16'h0000);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		cmd(`COC_SUB_FREEZE);
		rx(`COC_REG_STATUS, 32'h50);
		@(posedge aclk);
		end_of_test();
	end
endmodule // config_overlay_command_unit_bench
